// ===== hw/lcds_axil.sv
// AXI4-Lite slave turning word accesses into byte register accesses.
// Assumes a master that keeps one write and one read in flight.
`timescale 1ns/100ps
module lcds_axil (
	input  wire logic                      clk,
	input  wire logic                      nrst,
	input  wire logic [lcds_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                      awvalid,
	output logic                           awready,
	input  wire logic [31:0]               wdata,
	input  wire logic [3:0]                wstrb,
	input  wire logic                      wvalid,
	output logic                           wready,
	output logic [1:0]                     bresp,
	output logic                           bvalid,
	input  wire logic                      bready,
	input  wire logic [lcds_pkg::ADDR_W-1:0] araddr,
	input  wire logic                      arvalid,
	output logic                           arready,
	output logic [31:0]                    rdata,
	output logic [1:0]                     rresp,
	output logic                           rvalid,
	input  wire logic                      rready,
	lcds_reg_if.bus                        rp
);
	logic       aw_held_reg, aw_held_next, w_held_reg, w_held_next;
	logic [7:0] aw_idx_reg, aw_idx_next, w_data_reg, w_data_next;
	logic       w_lane_reg, w_lane_next;
	logic       bvalid_reg, bvalid_next, awready_reg, awready_next, wready_reg, wready_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic       rd_pend_reg, rd_pend_next, rvalid_reg, rvalid_next;
	logic       arready_reg, arready_next;
	logic [7:0] rd_idx_reg, rd_idx_next;
	logic [31:0] rdata_reg, rdata_next;
	logic       wr_hit, rd_hit, fire;

	// --------------------------------------------------------------
	// Write and read channels
	// --------------------------------------------------------------
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_idx_next  = aw_idx_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_lane_next  = w_lane_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rd_pend_next = 1'b0;
		rd_idx_next  = rd_idx_reg;
		rvalid_next  = rvalid_reg;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		wr_hit = (aw_idx_reg >= lcds_pkg::CTRL_IDX) && (aw_idx_reg <= lcds_pkg::MEM_LAST_IDX);
		rd_hit = (rd_idx_reg >= lcds_pkg::CTRL_IDX) && (rd_idx_reg <= lcds_pkg::MEM_LAST_IDX);
		fire   = aw_held_reg && w_held_reg && !bvalid_reg;
		if (awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			aw_idx_next  = awaddr[9:2];
		end
		if (wvalid && wready_reg) begin
			w_held_next = 1'b1;
			w_data_next = wdata[7:0];
			w_lane_next = wstrb[0];
		end
		if (bvalid_reg && bready) begin
			bvalid_next = 1'b0;
		end
		if (fire) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_hit ? lcds_pkg::RESP_OKAY : lcds_pkg::RESP_DECERR;
		end
		if (rvalid_reg && rready) begin
			rvalid_next = 1'b0;
		end
		if (arvalid && arready_reg) begin
			rd_pend_next = 1'b1;
			rd_idx_next  = araddr[9:2];
		end
		if (rd_pend_reg) begin
			rvalid_next = 1'b1;
			rdata_next  = rd_hit ? {24'h000000, rp.rd_data} : 32'h00000000;
			rresp_next  = rd_hit ? lcds_pkg::RESP_OKAY : lcds_pkg::RESP_DECERR;
		end
		awready_next = !aw_held_next && !bvalid_next;
		wready_next  = !w_held_next && !bvalid_next;
		arready_next = !rd_pend_next && !rvalid_next;
	end

	// Only lane 0 carries a register byte; other lanes are dropped
	assign rp.wr_en   = fire && wr_hit && w_lane_reg;
	assign rp.wr_idx  = aw_idx_reg;
	assign rp.wr_data = w_data_reg;
	assign rp.rd_idx  = rd_idx_reg;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			aw_held_reg <= 1'b0;
			aw_idx_reg  <= 8'h00;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= 2'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_idx_reg  <= 8'h00;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= 2'h0;
			rdata_reg   <= 32'h00000000;
			arready_reg <= 1'b0;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_idx_reg  <= aw_idx_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_lane_reg  <= w_lane_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			rd_pend_reg <= rd_pend_next;
			rd_idx_reg  <= rd_idx_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			arready_reg <= arready_next;
		end
	end

	assign awready = awready_reg;
	assign wready  = wready_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = arready_reg;
	assign rvalid  = rvalid_reg;
	assign rresp   = rresp_reg;
	assign rdata   = rdata_reg;
endmodule : lcds_axil

// ===== hw/lcds_timing.sv
// Common phase and frame polarity generator stepped by the LCD clock.
// Assumes lcd_clk is a slow level synchronous to clk.
`timescale 1ns/100ps
module lcds_timing (
	input  wire logic       clk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [1:0] mux_sel,
	input  wire logic       lcd_clk,
	output logic [1:0]      phase,
	output logic            polarity
);
	logic       lcd_clk_prev_reg, lcd_clk_prev_next;
	logic [1:0] phase_reg, phase_next;
	logic       pol_reg, pol_next;

	// --------------------------------------------------------------
	// Phase stepping
	// --------------------------------------------------------------
	always_comb begin
		lcd_clk_prev_next = lcd_clk;
		phase_next        = phase_reg;
		pol_next          = pol_reg;
		if (!run) begin
			phase_next = 2'h0;
			pol_next   = 1'b0;
		end else if (lcd_clk && !lcd_clk_prev_reg) begin
			// Wrap also covers a mode shrunk mid-frame
			if (phase_reg >= mux_sel) begin
				phase_next = 2'h0;
				pol_next   = !pol_reg;
			end else begin
				phase_next = phase_reg + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			lcd_clk_prev_reg <= 1'b0;
			phase_reg        <= 2'h0;
			pol_reg          <= 1'b0;
		end else begin
			lcd_clk_prev_reg <= lcd_clk_prev_next;
			phase_reg        <= phase_next;
			pol_reg          <= pol_next;
		end
	end

	assign phase    = phase_reg;
	assign polarity = pol_reg;
endmodule : lcds_timing

// ===== hw/lcds_top.sv
// Segment LCD controller: control register, display memory, pin drive.
// Assumes lcd_clk comes from a divided auxiliary clock, slower than clk.
//
// What this block does
// - Power-up clear zeroes every control register bit.
// - Drive off stops timing, holds common/segment lines low, ladder open.
// - Drive on generates common and segment waveforms, ladder closed.
// - General outputs follow display memory regardless of drive on.
// - Segment enable low deselects all segments; general outputs unaffected.
// - Mux select picks static, two, three or four multiplex.
// - Segment enable is ANDed with each segment memory bit.
// - Group field n makes groups 1..n segments, rest general outputs.
// - A general-output pin shows its memory bits, not segment drive.
// - Memory bit set turns a segment on, cleared turns it off.
// - Static uses common 0 and bits 0 and 4.
// - Two-multiplex uses commons 0-1 and bits 0,1,4,5.
// - Three-multiplex uses commons 0-2 and bits 0,1,2,4,5,6.
// - Four-multiplex uses all commons and all eight bits.
// - Bits unused by the mode act as plain memory, except after a mode shrunk mid-frame until the next LCD clock step.
// - Line timing is stepped by the LCD clock.
`timescale 1ns/100ps
module lcds_top (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic                        lcd_clk,
	input  wire logic [lcds_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	input  wire logic                        wvalid,
	output logic                             wready,
	output logic [1:0]                       bresp,
	output logic                             bvalid,
	input  wire logic                        bready,
	input  wire logic [lcds_pkg::ADDR_W-1:0] araddr,
	input  wire logic                        arvalid,
	output logic                             arready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic [lcds_pkg::COM_LINES-1:0]   common_line,
	output logic [lcds_pkg::SEG_PINS-1:0]    segment_line,
	output logic [lcds_pkg::SEG_PINS-1:0]    pin_is_output,
	output logic                             frame_polarity,
	output logic                             ladder_switch_on
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] mem_reg [lcds_pkg::MEM_BYTES];
	logic [7:0] mem_next [lcds_pkg::MEM_BYTES];
	logic [lcds_pkg::COM_LINES-1:0] com_reg, com_next;
	logic [lcds_pkg::SEG_PINS-1:0]  seg_reg, seg_next, gpo_reg, gpo_next;
	logic       pol_reg, pol_next, ladder_reg, ladder_next;
	logic [1:0] phase;
	logic       polarity;
	logic       drive_on, segment_enable;
	lcds_pkg::lcds_mux_t mux_mode;
	logic [2:0] output_group_sel;
	logic [3:0] wr_slot, rd_slot;
	lcds_reg_if rp ();

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	lcds_axil lcds_axil_i (
		.clk     (clk),
		.nrst    (nrst),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.rp      (rp.bus)
	);

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	assign drive_on         = ctrl_reg[lcds_pkg::DRIVE_ON_BIT];
	assign segment_enable   = ctrl_reg[lcds_pkg::SEG_EN_BIT];
	assign mux_mode = lcds_pkg::lcds_mux_t'({ctrl_reg[lcds_pkg::MUX_HI_BIT],
		ctrl_reg[lcds_pkg::MUX_LO_BIT]});
	assign output_group_sel = ctrl_reg[lcds_pkg::GROUP_MSB:lcds_pkg::GROUP_LSB];

	// ----------------------------------------------------------------
	// Frame timing
	// ----------------------------------------------------------------
	// LCD clock steps phases
	lcds_timing lcds_timing_i (
		.clk      (clk),
		.nrst     (nrst),
		.run      (drive_on),
		.mux_sel  (mux_mode),
		.lcd_clk  (lcd_clk),
		.phase    (phase),
		.polarity (polarity)
	);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	assign wr_slot = 4'(rp.wr_idx - lcds_pkg::MEM_FIRST_IDX);
	assign rd_slot = 4'(rp.rd_idx - lcds_pkg::MEM_FIRST_IDX);

	always_comb begin
		ctrl_next = ctrl_reg;
		for (int i = 0; i < lcds_pkg::MEM_BYTES; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (rp.wr_en) begin
			if (rp.wr_idx == lcds_pkg::CTRL_IDX) begin
				ctrl_next = rp.wr_data;
			end else begin
				mem_next[wr_slot] = rp.wr_data;
			end
		end
	end

	always_comb begin
		if (rp.rd_idx == lcds_pkg::CTRL_IDX) begin
			rp.rd_data = ctrl_reg;
		end else if (rd_slot < 4'(lcds_pkg::MEM_BYTES)) begin
			rp.rd_data = mem_reg[rd_slot];
		end else begin
			rp.rd_data = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= lcds_pkg::CTRL_RESET;
			for (int i = 0; i < lcds_pkg::MEM_BYTES; i++) begin
				mem_reg[i] <= lcds_pkg::MEM_RESET;
			end
		end else begin
			ctrl_reg <= ctrl_next;
			for (int i = 0; i < lcds_pkg::MEM_BYTES; i++) begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin drive
	// ----------------------------------------------------------------
	// Phase stays below the mux count except after a mode shrunk mid-frame, until the next LCD clock step; only then do unused bits reach a pin
	always_comb begin
		int  grp;
		int  bidx;
		logic bit_val;
		grp     = 0;
		bidx    = 0;
		bit_val = 1'b0;
		ladder_next = drive_on;
		pol_next    = drive_on && polarity;
		for (int k = 0; k < lcds_pkg::COM_LINES; k++) begin
			com_next[k] = drive_on && (k <= int'(mux_mode)) && (phase == 2'(k));
		end
		for (int p = 0; p < lcds_pkg::SEG_PINS; p++) begin
			grp = (p + lcds_pkg::FIXED_SEG_PINS) / lcds_pkg::PINS_PER_GROUP;
			// low nibble even, high nibble odd
			bidx    = (p % 2) * lcds_pkg::NIBBLE_W + int'(phase);
			bit_val = mem_reg[p / 2][bidx];
			gpo_next[p] = (p >= lcds_pkg::FIXED_SEG_PINS) && (grp > int'(output_group_sel));
			if (gpo_next[p]) begin
				seg_next[p] = bit_val;
			end else begin
				seg_next[p] = drive_on && segment_enable && bit_val;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			com_reg    <= '0;
			seg_reg    <= '0;
			gpo_reg    <= '0;
			pol_reg    <= 1'b0;
			ladder_reg <= 1'b0;
		end else begin
			com_reg    <= com_next;
			seg_reg    <= seg_next;
			gpo_reg    <= gpo_next;
			pol_reg    <= pol_next;
			ladder_reg <= ladder_next;
		end
	end

	assign common_line      = com_reg;
	assign segment_line     = seg_reg;
	assign pin_is_output    = gpo_reg;
	assign frame_polarity   = pol_reg;
	assign ladder_switch_on = ladder_reg;
endmodule : lcds_top

// ===== include/lcds_pkg.sv
// Constants shared by the segment LCD controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package lcds_pkg;

	// ----------------------------------------------------------------
	// Register map, as word indices (byte address is four times)
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_IDX      = 8'h30;
	localparam logic [7:0] MEM_FIRST_IDX = 8'h31;
	localparam logic [7:0] MEM_LAST_IDX  = 8'h3F;
	localparam int         MEM_BYTES     = 15;
	localparam int         ADDR_W        = 10;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RESET     = 8'h00;
	localparam int         DRIVE_ON_BIT   = 0;
	localparam int         SEG_EN_BIT     = 2;
	localparam int         MUX_LO_BIT     = 3;
	localparam int         MUX_HI_BIT     = 4;
	localparam int         GROUP_LSB      = 5;
	localparam int         GROUP_MSB      = 7;

	// ----------------------------------------------------------------
	// Pins and display memory layout
	// ----------------------------------------------------------------
	localparam int         SEG_PINS       = 30;
	localparam int         COM_LINES      = 4;
	localparam int         FIXED_SEG_PINS = 2;
	localparam int         PINS_PER_GROUP = 4;
	localparam int         NIBBLE_W       = 4;
	localparam logic [7:0] MEM_RESET      = 8'h00;

	// ----------------------------------------------------------------
	// Bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_DECERR    = 2'h3;

	typedef enum logic [1:0] {
		LCDS_STATIC,
		LCDS_MUX2,
		LCDS_MUX3,
		LCDS_MUX4
	} lcds_mux_t;

endpackage : lcds_pkg

// ===== include/lcds_reg_if.sv
// Byte register port between the bus slave and the register file.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface lcds_reg_if;
	logic       wr_en;
	logic [7:0] wr_idx;
	logic [7:0] wr_data;
	logic [7:0] rd_idx;
	logic [7:0] rd_data;

	modport bus  (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport regs (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : lcds_reg_if

// ===== verification/lcds_asserts.sv
// Port checker for the segment LCD controller.
// Assumes one clock domain and the slave's fixed answer delays.
`timescale 1ns/100ps
module lcds_checker (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic        lcd_clk,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic [3:0]  common_line,
	input wire logic [29:0] segment_line,
	input wire logic [29:0] pin_is_output,
	input wire logic        frame_polarity,
	input wire logic        ladder_switch_on
);
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// ---------
	// Bus
	// ---------
	sequence s_wr_take;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence s_rd_take;
		arvalid && arready;
	endsequence
	property p_wr_answer;
		s_wr_take |-> ##[1:2] bvalid;
	endproperty
	property p_wr_busy;
		s_wr_take |=> !awready && !wready;
	endproperty
	property p_rd_answer;
		s_rd_take |-> ##[2:3] rvalid;
	endproperty
	property p_b_release;
		bvalid && bready |=> !bvalid;
	endproperty
	property p_r_release;
		rvalid && rready |=> !rvalid && arready;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_wr_busy: assert property (p_wr_busy) else $error("write ready not lowered");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_b_release: assert property (p_b_release) else $error("bvalid held");
	a_r_release: assert property (p_r_release) else $error("read answer not released");

	// ---------
	// Pins
	// ---------
	property p_off;
		!ladder_switch_on |-> common_line == 4'h0 && !frame_polarity
			&& (segment_line & ~pin_is_output) == 30'h0;
	endproperty
	property p_on;
		ladder_switch_on |-> $onehot(common_line);
	endproperty
	property p_group;
		pin_is_output inside {30'h3FFFFFFC, 30'h3FFFFFC0, 30'h3FFFFC00, 30'h3FFFC000,
			30'h3FFC0000, 30'h3FC00000, 30'h3C000000, 30'h0};
	endproperty
	property p_step;
		ladder_switch_on && $past(ladder_switch_on) && $changed(common_line)
			|-> ($past(lcd_clk, 2) && !$past(lcd_clk, 3))
			|| ($past(lcd_clk, 3) && !$past(lcd_clk, 4));
	endproperty
	property p_pol;
		ladder_switch_on && $changed(frame_polarity) |-> common_line[0];
	endproperty
	a_off: assert property (p_off) else $error("lines active while off");
	a_on: assert property (p_on) else $error("no single common active");
	a_group: assert property (p_group) else $error("bad output group mask");
	a_step: assert property (p_step) else $error("phase moved without lcd clock");
	a_pol: assert property (p_pol) else $error("polarity off frame start");
endmodule : lcds_checker

bind lcds_top lcds_checker lcds_checker_i (.*);

// ===== verification/lcds_glass.sv
// Passive glass model: remembers which segment each common selected.
// Assumes digital common and segment levels from the controller.
`timescale 1ns/100ps
module lcds_glass (
	input wire logic         clk,
	input wire logic [3:0]   common_line,
	input wire logic [29:0]  segment_line,
	input wire logic [29:0]  pin_is_output,
	output logic     [119:0] lit
);
	// one cell per pin and common
	// Output pins are ignored; they drive no glass
	always @(posedge clk) begin
		for (int p = 0; p < 30; p++) begin
			for (int k = 0; k < 4; k++) begin
				if (common_line[k] && !pin_is_output[p])
					lit[4 * p + k] <= segment_line[p];
			end
		end
	end
endmodule : lcds_glass

// ===== verification/lcds_tb_top.sv
// Self-checking bench for the segment LCD controller.
// Assumes a 40 MHz clock and the slave's fixed answer delays.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end
module lcds_tb_top;
	logic         clk = 1'b0;
	logic         nrst = 1'b0;
	logic         lcd_clk = 1'b0;
	logic [9:0]   awaddr = 10'h0;
	logic [9:0]   araddr = 10'h0;
	logic [31:0]  wdata = 32'h0;
	logic [3:0]   wstrb = 4'h0;
	logic         awvalid = 1'b0;
	logic         wvalid = 1'b0;
	logic         bready = 1'b0;
	logic         arvalid = 1'b0;
	logic         rready = 1'b0;
	logic         awready, wready, bvalid, arready, rvalid, frame_polarity, ladder_switch_on;
	logic [1:0]   bresp, rresp;
	logic [31:0]  rdata;
	logic [3:0]   common_line;
	logic [29:0]  segment_line, pin_is_output;
	logic [119:0] lit;
	int           err_count = 0;
	int           checks = 0;
	int           ph = 0;
	logic         pol = 1'b0;
	logic [7:0]   ctl = 8'h00;
	logic [7:0]   mem [15];
	logic [1:0]   r;
	logic [31:0]  w;

	always #12.5 clk = ~clk;
	lcds_top lcds_top_i (.*);
	lcds_glass lcds_glass_i (.*);

	// ---------
	// Bus tasks
	// ---------
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] st);
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, d};
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		r = bresp;
	endtask : wr

	// Ready for the answer from the start; data taken at the handshake edge
	task automatic rd(input logic [7:0] idx);
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		r = rresp;
		w = rdata;
	endtask : rd

	task automatic wr_ctl(input logic [7:0] d);
		wr(lcds_pkg::CTRL_IDX, d, 4'h1);
		`CHK("ctrl resp", lcds_pkg::RESP_OKAY, r)
		ctl = d;
		if (!d[0]) begin
			ph = 0;
			pol = 1'b0;
		end
	endtask : wr_ctl

	task automatic step();
		lcd_clk <= 1'b1;
		@(posedge clk);
		lcd_clk <= 1'b0;
		repeat (3) @(posedge clk);
		if (ctl[0] && ph == int'(ctl[4:3])) begin
			ph = 0;
			pol = ~pol;
		end else if (ctl[0]) begin
			ph++;
		end
	endtask : step

	// ---------
	// Expected pins
	// ---------
	function automatic logic [29:0] omask(input logic [7:0] c);
		return 30'(30'h3FFFFFFC << (4 * c[7:5]));
	endfunction : omask

	function automatic logic [3:0] nib(input int p);
		return p[0] ? mem[p / 2][7:4] : mem[p / 2][3:0];
	endfunction : nib

	function automatic logic [29:0] exp_seg();
		logic [29:0] e;
		logic [29:0] om;
		logic [3:0]  nb;
		om = omask(ctl);
		for (int p = 0; p < 30; p++) begin
			nb = nib(p);
			e[p] = om[p] ? nb[ctl[0] ? ph : 0] : nb[ph] & ctl[0] & ctl[2];
		end
		return e;
	endfunction : exp_seg

	task automatic check_pins();
		repeat (2) @(posedge clk);
		`CHK("common", ctl[0] ? 4'(1 << ph) : 4'h0, common_line)
		`CHK("segment", exp_seg(), segment_line)
		`CHK("outputs", omask(ctl), pin_is_output)
		`CHK("polarity", pol, frame_polarity)
		`CHK("ladder", ctl[0], ladder_switch_on)
	endtask : check_pins

	// ---------
	// Scenarios
	// ---------
	task automatic t_regs();
		wr(lcds_pkg::CTRL_IDX, 8'hFE, 4'h0);
		rd(lcds_pkg::CTRL_IDX);
		`CHK("no lane write", 32'h0, w)
		wr_ctl(8'hFE);
		rd(lcds_pkg::CTRL_IDX);
		`CHK("ctrl read", 32'hFE, w)
		wr(8'h40, 8'h12, 4'h1);
		`CHK("unmapped wr", lcds_pkg::RESP_DECERR, r)
		rd(8'h40);
		`CHK("unmapped rd", {lcds_pkg::RESP_DECERR, 32'h0}, {r, w})
		wr_ctl(8'h05);
		for (int m = 0; m < 15; m++) begin
			mem[m] = 8'(m * 37 + 150);
			wr(8'(lcds_pkg::MEM_FIRST_IDX + m), mem[m], 4'h1);
		end
		rd(lcds_pkg::MEM_FIRST_IDX + 8'h3);
		`CHK("spare bits", {24'h0, mem[3]}, w)
		check_pins();
		$display("test regs done");
	endtask : t_regs

	task automatic t_modes();
		logic [119:0] ge;
		logic [119:0] gm;
		logic [3:0]   nb;
		for (int md = 0; md < 4; md++) begin
			wr_ctl(8'h00);
			wr_ctl(8'hE5 | 8'(md << 3));
			check_pins();
			for (int i = 0; i < 2 * (md + 1); i++) begin
				step();
				check_pins();
			end
			ge = '0;
			gm = '0;
			for (int p = 0; p < 30; p++) begin
				nb = nib(p);
				for (int k = 0; k <= md; k++) begin
					gm[4 * p + k] = 1'b1;
					ge[4 * p + k] = nb[k];
				end
			end
			`CHK("glass", ge, lit & gm)
		end
		$display("test modes done");
	endtask : t_modes

	task automatic t_blank();
		wr_ctl(8'h00);
		wr_ctl(8'h79);
		// uniform nibbles give a static output level
		mem[14] = 8'hF0;
		wr(lcds_pkg::MEM_LAST_IDX, mem[14], 4'h1);
		check_pins();
		`CHK("static out", 2'b10, segment_line[29:28])
		step();
		check_pins();
		`CHK("static out", 2'b10, segment_line[29:28])
		$display("test blank done");
	endtask : t_blank

	// every group value, drive off and on
	task automatic t_groups();
		for (int n = 0; n < 8; n++) begin
			wr_ctl(8'(n << 5));
			check_pins();
			wr_ctl(8'(n << 5) | 8'h1D);
			step();
			check_pins();
		end
		$display("test groups done");
	endtask : t_groups

	// reset in mid-run clears the control register
	task automatic t_reset();
		wr_ctl(8'hFF);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		ctl = 8'h00;
		ph = 0;
		pol = 1'b0;
		for (int m = 0; m < 15; m++) mem[m] = 8'h00;
		rd(lcds_pkg::CTRL_IDX);
		`CHK("ctrl reset", 32'h0, w)
		check_pins();
		$display("test reset done");
	endtask : t_reset

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// Hang guard, far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		close_out();
	end

	initial begin
		for (int m = 0; m < 15; m++) mem[m] = 8'h00;
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_modes();
		t_blank();
		t_groups();
		t_reset();
		close_out();
	end
endmodule : lcds_tb_top
